// >>> core/acis_top.sv
// Top of the channel 1, 2, 3 input select register with its source decode.
//
// Added by the designer: the address map and the APB interface to the registers.
`timescale 1ns/100ps
`default_nettype none
module acis_top
  import acis_pkg::*;
(
  // Clock, reset and enable
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  // APB
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // Sample multiplexer in use, 1 selects B
  input wire logic MUX_B_ACTIVE,
  // Channel sources
  output logic [4:0] CH1_POS,
  output logic [4:0] CH2_POS,
  output logic [4:0] CH3_POS,
  output logic [4:0] CH1_NEG,
  output logic [4:0] CH2_NEG,
  output logic [4:0] CH3_NEG
);

  logic [15:0] select_ff;
  logic [7:0] control_ff;
  logic [31:0] rdata_ff;
  logic [4:0] ch1p_ff, ch2p_ff, ch3p_ff, ch1n_ff, ch2n_ff, ch3n_ff;

  logic rdy, err, wr_sel, wr_ctl, rd_acc;
  logic [1:0] rd_idx;

  acis_apb_slave u_bus (
    .psel(PSEL),
    .penable(PENABLE),
    .pwrite(PWRITE),
    .paddr(PADDR),
    .pready(rdy),
    .pslverr(err),
    .wr_select(wr_sel),
    .wr_control(wr_ctl),
    .rd_access(rd_acc),
    .rd_index(rd_idx)
  );

  // A frozen block must not complete a transfer, or a write would be lost.
  assign PREADY = rdy & CE;
  assign PSLVERR = err & CE;

  wire logic twelve_bit = control_ff[ACIS_CTL_TWELVE_BIT];
  wire logic [2:0] opamp_en = control_ff[ACIS_CTL_OPAMP_LSB +: 3];
  wire logic [2:0] cmp_en = control_ff[ACIS_CTL_CMP_LSB +: 3];

  // Fields that vanish in twelve-bit mode read as zero and decode as zero.
  wire logic [15:0] live_mask = twelve_bit ? ACIS_SELECT_MASK_12B : ACIS_SELECT_MASK;
  wire logic [15:0] select_vis = select_ff & live_mask;
  wire logic [15:0] nxt_select = PWDATA[15:0] & live_mask;
  wire logic [7:0] nxt_control = PWDATA[7:0] & ACIS_CONTROL_MASK;

  wire logic [31:0] status_word = {16'h0000, 2'b00, ch1n_ff, ch1p_ff, MUX_B_ACTIVE, 3'b000};
  wire logic [31:0] nxt_rdata = (rd_idx == 2'd0) ? {16'h0000, select_vis} :
                                (rd_idx == 2'd1) ? {24'h000000, control_ff} :
                                (rd_idx == 2'd2) ? status_word : 32'h00000000;

  logic [4:0] a1p, a2p, a3p, a1n, a2n, a3n, b1p, b2p, b3p, b1n, b2n, b3n;

  acis_chan_decode u_mux_a (
    .pos_sel(select_vis[ACIS_MUXA_POS_BIT]),
    .neg_sel(select_vis[ACIS_MUXA_NEG_LSB +: 2]),
    .opamp_en(opamp_en),
    .cmp_en(cmp_en),
    .ch1_pos(a1p),
    .ch2_pos(a2p),
    .ch3_pos(a3p),
    .ch1_neg(a1n),
    .ch2_neg(a2n),
    .ch3_neg(a3n)
  );

  acis_chan_decode u_mux_b (
    .pos_sel(select_vis[ACIS_MUXB_POS_BIT]),
    .neg_sel(select_vis[ACIS_MUXB_NEG_LSB +: 2]),
    .opamp_en(opamp_en),
    .cmp_en(cmp_en),
    .ch1_pos(b1p),
    .ch2_pos(b2p),
    .ch3_pos(b3p),
    .ch1_neg(b1n),
    .ch2_neg(b2n),
    .ch3_neg(b3n)
  );

  wire logic use_b = MUX_B_ACTIVE;

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      select_ff <= ACIS_SELECT_RESET;
      control_ff <= ACIS_CONTROL_RESET;
    end else if (CE) begin
      if (wr_sel) begin
        select_ff <= nxt_select;
      end
      if (wr_ctl) begin
        control_ff <= nxt_control;
      end
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      rdata_ff <= 32'h00000000;
    end else if (CE && PSEL && !PENABLE && !PWRITE) begin
      rdata_ff <= nxt_rdata;
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      ch1p_ff <= ACIS_SRC_AN0;
      ch2p_ff <= ACIS_SRC_AN1;
      ch3p_ff <= ACIS_SRC_AN2;
      ch1n_ff <= ACIS_SRC_LOW_REFERENCE;
      ch2n_ff <= ACIS_SRC_LOW_REFERENCE;
      ch3n_ff <= ACIS_SRC_LOW_REFERENCE;
    end else if (CE) begin
      ch1p_ff <= use_b ? b1p : a1p;
      ch2p_ff <= use_b ? b2p : a2p;
      ch3p_ff <= use_b ? b3p : a3p;
      ch1n_ff <= use_b ? b1n : a1n;
      ch2n_ff <= use_b ? b2n : a2n;
      ch3n_ff <= use_b ? b3n : a3n;
    end
  end

  assign PRDATA = rdata_ff;
  assign CH1_POS = ch1p_ff;
  assign CH2_POS = ch2p_ff;
  assign CH3_POS = ch3p_ff;
  assign CH1_NEG = ch1n_ff;
  assign CH2_NEG = ch2n_ff;
  assign CH3_NEG = ch3n_ff;

endmodule
`default_nettype wire

// >>> inc/acis_pkg.sv
// Package holding offsets, field layouts, reset values and source codes for the channel input select block.
package acis_pkg;

  localparam logic [11:0] ACIS_SELECT_OFFSET = 12'h000;
  localparam logic [11:0] ACIS_CONTROL_OFFSET = 12'h004;
  localparam logic [11:0] ACIS_STATUS_OFFSET = 12'h008;

  localparam int ACIS_MUXA_POS_BIT = 0;
  localparam int ACIS_MUXA_NEG_LSB = 1;
  localparam int ACIS_MUXB_POS_BIT = 8;
  localparam int ACIS_MUXB_NEG_LSB = 9;
  localparam int ACIS_CTL_TWELVE_BIT = 0;
  localparam int ACIS_CTL_OPAMP_LSB = 1;
  localparam int ACIS_CTL_CMP_LSB = 4;
  localparam int ACIS_CTL_ACTIVE_MUX = 7;

  localparam logic [15:0] ACIS_SELECT_MASK = 16'h0707;
  // In twelve-bit mode only the multiplexer A positive select bit stays implemented.
  localparam logic [15:0] ACIS_SELECT_MASK_12B = 16'h0001;
  localparam logic [15:0] ACIS_SELECT_RESET = 16'h0000;
  localparam logic [7:0] ACIS_CONTROL_RESET = 8'h00;
  localparam logic [7:0] ACIS_CONTROL_MASK = 8'hFF;

  // Source codes driven to the analog multiplexers.
  localparam logic [4:0] ACIS_SRC_AN0 = 5'h00;
  localparam logic [4:0] ACIS_SRC_AN1 = 5'h01;
  localparam logic [4:0] ACIS_SRC_AN2 = 5'h02;
  localparam logic [4:0] ACIS_SRC_AN3 = 5'h03;
  localparam logic [4:0] ACIS_SRC_AN6 = 5'h06;
  localparam logic [4:0] ACIS_SRC_AN7 = 5'h07;
  localparam logic [4:0] ACIS_SRC_AN8 = 5'h08;
  localparam logic [4:0] ACIS_SRC_AN9 = 5'h09;
  localparam logic [4:0] ACIS_SRC_AN10 = 5'h0A;
  localparam logic [4:0] ACIS_SRC_AN11 = 5'h0B;
  localparam logic [4:0] ACIS_SRC_OA1 = 5'h11;
  localparam logic [4:0] ACIS_SRC_OA2 = 5'h12;
  localparam logic [4:0] ACIS_SRC_OA3 = 5'h13;
  localparam logic [4:0] ACIS_SRC_CMP_BASE = 5'h14;
  localparam logic [4:0] ACIS_SRC_LOW_REFERENCE = 5'h1F;

endpackage

// >>> core/acis_chan_decode.sv
// Decoder from the select fields to the three channel source codes for one multiplexer.
`timescale 1ns/100ps
`default_nettype none
module acis_chan_decode
  import acis_pkg::*;
(
  // Select fields
  input wire logic pos_sel,
  input wire logic [1:0] neg_sel,
  // Op amp and comparator enables, index 0 is unit 1
  input wire logic [2:0] opamp_en,
  input wire logic [2:0] cmp_en,
  // Channel sources
  output logic [4:0] ch1_pos,
  output logic [4:0] ch2_pos,
  output logic [4:0] ch3_pos,
  output logic [4:0] ch1_neg,
  output logic [4:0] ch2_neg,
  output logic [4:0] ch3_neg
);

  // A shared pin follows its op amp, else its comparator claim, else stays a plain pin.
  function automatic logic [4:0] shared_src(input logic [4:0] pin, input logic [4:0] oa, input logic oa_on,
                                            input logic cmp_on, input logic [4:0] cmp_src);
    shared_src = oa_on ? oa : (cmp_on ? cmp_src : pin);
  endfunction

  wire logic [4:0] src_an0 = shared_src(ACIS_SRC_AN0, ACIS_SRC_OA2, opamp_en[1], cmp_en[1], ACIS_SRC_CMP_BASE + 5'h01);
  wire logic [4:0] src_an3 = shared_src(ACIS_SRC_AN3, ACIS_SRC_OA1, opamp_en[0], cmp_en[0], ACIS_SRC_CMP_BASE);
  wire logic [4:0] src_an6 = shared_src(ACIS_SRC_AN6, ACIS_SRC_OA3, opamp_en[2], cmp_en[2], ACIS_SRC_CMP_BASE + 5'h02);

  assign ch1_pos = pos_sel ? src_an3 : src_an0;
  assign ch2_pos = pos_sel ? src_an0 : ACIS_SRC_AN1;
  assign ch3_pos = pos_sel ? src_an6 : ACIS_SRC_AN2;

  wire logic neg_high = neg_sel == 2'b11;
  wire logic neg_mid = neg_sel == 2'b10;
  assign ch1_neg = neg_high ? ACIS_SRC_AN9 : (neg_mid ? src_an6 : ACIS_SRC_LOW_REFERENCE);
  assign ch2_neg = neg_high ? ACIS_SRC_AN10 : (neg_mid ? ACIS_SRC_AN7 : ACIS_SRC_LOW_REFERENCE);
  assign ch3_neg = neg_high ? ACIS_SRC_AN11 : (neg_mid ? ACIS_SRC_AN8 : ACIS_SRC_LOW_REFERENCE);

endmodule
`default_nettype wire

// >>> core/acis_apb_slave.sv
// APB slave front end: decode, zero wait state ready and error on unmapped addresses.
`timescale 1ns/100ps
`default_nettype none
module acis_apb_slave
  import acis_pkg::*;
(
  // APB request
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  // Decoded strokes
  output logic pready,
  output logic pslverr,
  output logic wr_select,
  output logic wr_control,
  output logic rd_access,
  output logic [1:0] rd_index
);

  wire logic access = psel & penable;
  wire logic hit_sel = paddr == ACIS_SELECT_OFFSET;
  wire logic hit_ctl = paddr == ACIS_CONTROL_OFFSET;
  wire logic hit_sts = paddr == ACIS_STATUS_OFFSET;
  wire logic mapped = hit_sel | hit_ctl | hit_sts;

  // Always ready in the first access cycle; the top masks this with CE, so the bus waits on this block only while CE is low.
  assign pready = access;
  assign pslverr = access & ~mapped;
  assign wr_select = access & pwrite & hit_sel;
  assign wr_control = access & pwrite & hit_ctl;
  assign rd_access = access & ~pwrite;
  assign rd_index = hit_sel ? 2'd0 : (hit_ctl ? 2'd1 : (hit_sts ? 2'd2 : 2'd3));

endmodule
`default_nettype wire

// >>> testbench/acis_checker.sv
// Port-level checks of the channel input select block.
`timescale 1ns/100ps
`default_nettype none
module acis_top_checker (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire logic PSLVERR,
  input wire logic [4:0] CH1_POS,
  input wire logic [4:0] CH2_POS,
  input wire logic [4:0] CH3_POS,
  input wire logic [4:0] CH1_NEG,
  input wire logic [4:0] CH2_NEG,
  input wire logic [4:0] CH3_NEG
);
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);
  ready_zero_wait_a: assert property (PSEL && PENABLE && CE |-> PREADY) else $error("ready missing");
  ready_idle_a: assert property (!(PSEL && PENABLE) |-> !PREADY) else $error("ready outside access");
  err_unmapped_a: assert property (PREADY && PADDR > 12'h008 |-> PSLVERR) else $error("no error on hole");
  err_unmapped_rd_a: assert property (PSLVERR && !PWRITE |-> PRDATA == 32'h0) else $error("hole read not zero");
  err_select_a: assert property (PREADY && PADDR == 12'h000 |-> !PSLVERR) else $error("error on select");
  rsvd_zero_a: assert property (PREADY && !PWRITE && PADDR == 12'h000 |-> PRDATA[31:11] == 21'h0 && PRDATA[7:3] == 5'h0)
    else $error("reserved bits set");
  neg_low_ref_a: assert property ((CH1_NEG == 5'h1F) == (CH3_NEG == 5'h1F) && (CH2_NEG == 5'h1F) == (CH3_NEG == 5'h1F))
    else $error("low reference split");
  neg_top_a: assert property (CH2_NEG == 5'h0A |-> CH1_NEG == 5'h09 && CH3_NEG == 5'h0B) else $error("neg code 11 split");
  neg_mid_a: assert property (CH2_NEG == 5'h07 |-> CH3_NEG == 5'h08) else $error("neg code 10 split");
  pos_low_a: assert property (CH2_POS == 5'h01 |-> CH3_POS == 5'h02) else $error("pos code 0 split");
endmodule
bind acis_top acis_top_checker u_chk (.CLK(CLK), .RESETN(RESETN), .CE(CE), .PSEL(PSEL), .PENABLE(PENABLE),
  .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .CH1_POS(CH1_POS),
  .CH2_POS(CH2_POS), .CH3_POS(CH3_POS), .CH1_NEG(CH1_NEG), .CH2_NEG(CH2_NEG), .CH3_NEG(CH3_NEG));
`default_nettype wire

// >>> testbench/acis_mux_model.sv
// Converter side that picks which sample multiplexer is in use.
`timescale 1ns/100ps
`default_nettype none
module acis_mux_model (
  input wire logic clk,
  input wire logic resetn,
  input wire logic want_b,
  output var logic mux_b_active
);
  // The converter swaps multiplexers only on a clock edge, never mid-cycle.
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) mux_b_active <= 1'b0;
    else mux_b_active <= want_b;
  end
endmodule
`default_nettype wire

// >>> testbench/tb_acis_top.sv
// Self-checking bench of the channel input select block.
`timescale 1ns/100ps
`default_nettype none
module tb_acis_top;
  import acis_pkg::*;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, mb, want_b, smp;
  logic [11:0] PADDR;
  logic [31:0] PWDATA, PRDATA, c, w;
  logic [4:0] p1, p2, p3, n1, n2, n3;
  logic [31:0] rq[$];
  logic [29:0] cq[$];
  int mismatches = 0, checks = 0;
  acis_top DUT (.CLK(CLK), .RESETN(RESETN), .CE(1'b1), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE),
    .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .MUX_B_ACTIVE(mb),
    .CH1_POS(p1), .CH2_POS(p2), .CH3_POS(p3), .CH1_NEG(n1), .CH2_NEG(n2), .CH3_NEG(n3));
  acis_mux_model u_far (.clk(CLK), .resetn(RESETN), .want_b(want_b), .mux_b_active(mb));
  initial begin
    CLK = 1'b0;
    forever #2.5 CLK = ~CLK;
  end
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic finish_test;
    if (mismatches == 0 && checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [31:0] e);
    int n;
    n = 0;
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    if (!wr) rq.push_back(e);
    @(posedge CLK) PENABLE <= 1'b1;
    do begin
      @(posedge CLK);
      n++;
    end while (PREADY !== 1'b1 && n < 50);
    if (n >= 50) mismatches++;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask
  // Op amp output wins over a comparator claim, which wins over the plain pin.
  function automatic logic [4:0] pk(input int i, input logic [4:0] an, input logic [7:0] k);
    return k[1+i] ? 5'(5'h11 + i) : k[4+i] ? 5'(5'h14 + i) : an;
  endfunction
  function automatic logic [29:0] ex(input logic [7:0] k, input logic [15:0] s, input logic m);
    logic p;
    logic [1:0] n;
    p = m ? s[8] & ~k[0] : s[0];
    n = k[0] ? 2'h0 : m ? s[10:9] : s[2:1];
    return {p ? {pk(0, 5'h03, k), pk(1, 5'h00, k), pk(2, 5'h06, k)} : {pk(1, 5'h00, k), 5'h01, 5'h02},
      n == 2'h3 ? {5'h09, 5'h0A, 5'h0B} : n == 2'h2 ? {pk(2, 5'h06, k), 5'h07, 5'h08} : {3{5'h1F}}};
  endfunction
  task automatic chk_ch(input logic [29:0] e);
    repeat (2) @(posedge CLK);
    cq.push_back(e);
    smp <= 1'b1;
    @(posedge CLK) smp <= 1'b0;
  endtask
  always @(posedge CLK) begin
    if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE) cmp("read", rq.pop_front(), PRDATA);
    if (PSEL && PENABLE && PREADY === 1'b1) cmp("slverr", {31'h0, PADDR > ACIS_STATUS_OFFSET}, {31'h0, PSLVERR});
    if (smp) cmp("chan", {2'h0, cq.pop_front()}, {2'h0, p1, p2, p3, n1, n2, n3});
  end
  initial begin
    {RESETN, PSEL, PENABLE, PWRITE, want_b, smp} = '0;
    PADDR = 12'h000;
    PWDATA = 32'h0;
    void'($urandom(99385));
    repeat (16) @(posedge CLK);
    RESETN <= 1'b1;
    @(posedge CLK);
    apb(1'b0, ACIS_SELECT_OFFSET, 32'h0, 32'h0);
    chk_ch(ex(8'h00, 16'h0000, 1'b0));
    for (int i = 0; i < 40; i++) begin
      c = $urandom;
      w = $urandom;
      want_b <= c[31];
      apb(1'b1, ACIS_CONTROL_OFFSET, c, 32'h0);
      apb(1'b1, ACIS_SELECT_OFFSET, w, 32'h0);
      w = w & (c[0] ? 32'h1 : 32'h707);
      apb(1'b0, ACIS_SELECT_OFFSET, 32'h0, w);
      apb(1'b0, ACIS_CONTROL_OFFSET, 32'h0, c & 32'hFF);
      chk_ch(ex(c[7:0], w[15:0], c[31]));
    end
    // A write to a hole must leave the select register alone.
    apb(1'b1, 12'h00C, 32'hFFFF, 32'h0);
    apb(1'b0, 12'h00C, 32'h0, 32'h0);
    apb(1'b0, ACIS_SELECT_OFFSET, 32'h0, w);
    finish_test();
  end
  initial begin
    #50000;
    mismatches++;
    finish_test();
  end
endmodule
`default_nettype wire
